// >>> wave_shaper.sv
/*
  Standard waveform shaper: square, triangle, ramp and pulse shapes from
  a recomputed point table, played out one point per step to the DAC.
  Assumes parameter writes arrive on REF_CLK; TRIG_IN is asynchronous.
*/
// Notes on behaviour
// - Square, triangle use 1000-point table at low rate
// - Repetition rate is clock over period (at least ten clocks)
// - Above the break, points per period shrink
// - Never fewer than ten points per period
// - Square duty is percent, default half period
// - Triggered triangle starts at phase; continuous ignores it
// - Ramp delay, rise, fall are period percents
// - Ramp total within period; remainder held flat
// - Pulse total within period; remainder held flat
// - Any shape change recomputes the whole table
// - Low-rate frequency change is coherent, no recompute
// - Amplitude write replaces amplitude for every mode
// - Offset write replaces offset for every mode
// - Restore returns shape parameters to defaults
// - Ramp and pulse tables hold 1000 points at low rate
`timescale 1ns/1ps
module wave_shaper (
  // Clock and reset
  input  wire logic        REF_CLK,
  input  wire logic        RST,
  // Shape and run control
  input  wire logic [1:0]  SHAPE_SEL,
  input  wire logic        TRIG_MODE,
  input  wire logic        TRIG_IN,
  // Parameter write port
  input  wire logic        WR_STB,
  input  wire logic [1:0]  WR_SHAPE,
  input  wire logic [3:0]  WR_ID,
  input  wire logic [15:0] WR_VAL,
  // Sample stream and status
  output logic [11:0]      DAC_DATA,
  output logic             SAMPLE_VALID,
  output logic             TABLE_BUSY,
  output logic             PARAM_REJECT,
  output logic [9:0]       TABLE_POINTS
);

  typedef struct packed {
    wave_shaper_pkg::rec_state_t state;
    wave_shaper_pkg::params_t    prm;
    logic [1:0]  shape_seen;
    logic [1:0]  shape_act;
    logic [1:0]  cshape;
    logic [9:0]  npts;
    logic [9:0]  cn;
    logic [9:0]  ci;
    logic [9:0]  b0;
    logic [9:0]  b1;
    logic [9:0]  b2;
    logic [9:0]  b3;
    logic        fall;
    logic        dirty;
    logic        tbl_ok;
    logic [9:0]  rd_idx;
    logic [19:0] acc;
    logic        running;
    logic        trig1;
    logic        trig2;
    logic        trig3;
    logic [11:0] dac;
    logic        busy;
    logic        reject;
    logic        valid;
  } shaper_state_t;

  localparam shaper_state_t S_RST = '{wave_shaper_pkg::ST_IDLE,
    wave_shaper_pkg::PRM_DEF, 2'h0, 2'h0, 2'h0, 10'h3E8, 10'h3E8, 10'h000,
    10'h000, 10'h000, 10'h000, 10'h000, 1'b0, 1'b1, 1'b0, 10'h000,
    20'h00000, 1'b0, 1'b0, 1'b0, 1'b0, 12'h800, 1'b1, 1'b0, 1'b0};

  shaper_state_t s_q;
  shaper_state_t s_d;

  logic [11:0] table_mem [wave_shaper_pkg::TBL_PTS];
  logic        wr_en;
  logic [9:0]  wr_addr;
  logic [11:0] wr_data;
  logic [11:0] tbl_rd;
  logic        div_go;
  logic [21:0] div_num;
  logic [21:0] div_den;
  logic        div_done;
  logic [21:0] div_quo;
  logic        trig_rise;
  logic [9:0]  start_idx;

  function automatic logic [9:0] n_for(input logic [19:0] per);
    if (per >= 20'(wave_shaper_pkg::TBL_PTS))
      n_for = 10'(wave_shaper_pkg::TBL_PTS);
    else if (per < 20'(wave_shaper_pkg::MIN_PTS))
      n_for = 10'(wave_shaper_pkg::MIN_PTS);
    else
      n_for = per[9:0];
  endfunction

  function automatic logic [9:0] pct_pts(input logic [6:0] p,
                                         input logic [9:0] n);
    logic [16:0] prod;
    prod = 17'(p) * 17'(n);
    pct_pts = 10'(prod / 17'(wave_shaper_pkg::PCT_FULL));
  endfunction

  function automatic logic [11:0] scale_out(input logic [11:0] s,
                                            input logic [11:0] a,
                                            input logic [11:0] o);
    logic signed [13:0] c;
    logic signed [26:0] p;
    logic signed [15:0] v;
    c = $signed({2'b00, s}) - 14'sd2048;
    p = 27'(c) * 27'($signed({1'b0, a}));
    v = 16'(p >>> 12) + $signed({{4{o[11]}}, o}) + 16'sd2048;
    if (v < 16'sd0)
      scale_out = wave_shaper_pkg::SAMPLE_LOW;
    else if (v > 16'sd4095)
      scale_out = wave_shaper_pkg::SAMPLE_MAX;
    else
      scale_out = v[11:0];
  endfunction

  wave_divider #(
    .W (wave_shaper_pkg::DIV_W)
  ) u_div (
    .clk   (REF_CLK),
    .rst   (RST),
    .start (div_go),
    .num   (div_num),
    .den   (div_den),
    .done  (div_done),
    .quo   (div_quo)
  );

  assign tbl_rd = table_mem[s_q.rd_idx];
  assign trig_rise = s_q.trig2 & ~s_q.trig3;
  assign start_idx = (TRIG_MODE && s_q.shape_act == wave_shaper_pkg::SHP_TRI)
    ? 10'((19'(s_q.prm.phase) * 19'(s_q.npts)) / 19'(wave_shaper_pkg::DEG_FULL))
    : 10'h000;

  always_comb
  begin
    logic        ev;
    logic        bad;
    logic        step;
    logic        adv;
    logic [9:0]  nxt;
    logic [19:0] acc_up;
    logic [11:0] val;
    logic [8:0]  rsum;
    logic [8:0]  psum;
    ev = 1'b0;
    bad = 1'b0;
    step = 1'b0;
    adv = 1'b0;
    nxt = '0;
    acc_up = '0;
    val = '0;
    rsum = '0;
    psum = '0;
    s_d = s_q;
    wr_en = 1'b0;
    wr_addr = '0;
    wr_data = '0;
    div_go = 1'b0;
    div_num = '0;
    div_den = 22'h000001;
    s_d.reject = 1'b0;
    // Valid follows the index by one clock, like the sample
    s_d.valid = s_q.running;
    s_d.trig1 = TRIG_IN;
    s_d.trig2 = s_q.trig1;
    s_d.trig3 = s_q.trig2;
    s_d.shape_seen = SHAPE_SEL;

    if (WR_STB)
    begin
      case (WR_ID)
        wave_shaper_pkg::PID_PERIOD:
        begin
          bad = (WR_VAL == 16'h0000);
          s_d.prm.period = 20'(WR_VAL);
          ev = n_for(20'(WR_VAL)) != n_for(s_q.prm.period);
        end
        wave_shaper_pkg::PID_AMP: s_d.prm.amp = WR_VAL[11:0];
        wave_shaper_pkg::PID_OFFS: s_d.prm.offs = WR_VAL[11:0];
        wave_shaper_pkg::PID_DUTY:
        begin
          bad = WR_SHAPE != wave_shaper_pkg::SHP_SQUARE ||
                WR_VAL > 16'(wave_shaper_pkg::PCT_FULL);
          s_d.prm.duty = WR_VAL[6:0];
          ev = 1'b1;
        end
        wave_shaper_pkg::PID_PHASE:
        begin
          bad = WR_SHAPE != wave_shaper_pkg::SHP_TRI ||
                WR_VAL >= 16'(wave_shaper_pkg::DEG_FULL);
          s_d.prm.phase = WR_VAL[8:0];
        end
        wave_shaper_pkg::PID_DELAY, wave_shaper_pkg::PID_RISE,
        wave_shaper_pkg::PID_HIGH, wave_shaper_pkg::PID_FALL:
        begin
          ev = 1'b1;
          bad = WR_VAL > 16'(wave_shaper_pkg::PCT_FULL);
          if (WR_SHAPE == wave_shaper_pkg::SHP_RAMP)
          begin
            case (WR_ID)
              wave_shaper_pkg::PID_DELAY: s_d.prm.rdel = WR_VAL[6:0];
              wave_shaper_pkg::PID_RISE:  s_d.prm.rris = WR_VAL[6:0];
              wave_shaper_pkg::PID_FALL:  s_d.prm.rfal = WR_VAL[6:0];
              default: bad = 1'b1;
            endcase
          end
          else if (WR_SHAPE == wave_shaper_pkg::SHP_PULSE)
          begin
            case (WR_ID)
              wave_shaper_pkg::PID_DELAY: s_d.prm.pdel = WR_VAL[6:0];
              wave_shaper_pkg::PID_RISE:  s_d.prm.pris = WR_VAL[6:0];
              wave_shaper_pkg::PID_HIGH:  s_d.prm.phig = WR_VAL[6:0];
              default: s_d.prm.pfal = WR_VAL[6:0];
            endcase
          end
          else
            bad = 1'b1;
        end
        wave_shaper_pkg::PID_RESTORE:
        begin
          // factory values for the named shape
          ev = 1'b1;
          s_d.prm.period = wave_shaper_pkg::DEF_PERIOD;
          s_d.prm.amp = wave_shaper_pkg::DEF_AMP;
          s_d.prm.offs = wave_shaper_pkg::DEF_OFFS;
          case (WR_SHAPE)
            wave_shaper_pkg::SHP_SQUARE:
              s_d.prm.duty = wave_shaper_pkg::DEF_DUTY;
            wave_shaper_pkg::SHP_TRI:
              s_d.prm.phase = wave_shaper_pkg::DEF_PHASE;
            wave_shaper_pkg::SHP_RAMP:
            begin
              s_d.prm.rdel = wave_shaper_pkg::DEF_RDEL;
              s_d.prm.rris = wave_shaper_pkg::DEF_RRIS;
              s_d.prm.rfal = wave_shaper_pkg::DEF_RFAL;
            end
            default:
            begin
              s_d.prm.pdel = wave_shaper_pkg::DEF_PDEL;
              s_d.prm.pris = wave_shaper_pkg::DEF_PRIS;
              s_d.prm.phig = wave_shaper_pkg::DEF_PHIG;
              s_d.prm.pfal = wave_shaper_pkg::DEF_PFAL;
            end
          endcase
        end
        default: bad = 1'b1;
      endcase
      rsum = 9'(s_d.prm.rdel) + 9'(s_d.prm.rris) + 9'(s_d.prm.rfal);
      psum = 9'(s_d.prm.pdel) + 9'(s_d.prm.pris) + 9'(s_d.prm.phig)
           + 9'(s_d.prm.pfal);
      if (bad || rsum > 9'(wave_shaper_pkg::PCT_FULL) ||
          psum > 9'(wave_shaper_pkg::PCT_FULL))
      begin
        s_d.prm = s_q.prm;
        s_d.reject = 1'b1;
        ev = 1'b0;
      end
    end

    // Playback: one point per step
    if (s_q.npts < 10'(wave_shaper_pkg::TBL_PTS) ||
        s_q.prm.period < 20'(wave_shaper_pkg::TBL_PTS))
    begin
      step = 1'b1;
      acc_up = '0;
    end
    else
    begin
      acc_up = s_q.acc + 20'(wave_shaper_pkg::TBL_PTS);
      step = acc_up >= s_q.prm.period;
      if (step)
        acc_up = acc_up - s_q.prm.period;
    end
    nxt = (s_q.rd_idx >= s_q.npts - 10'h001) ? 10'h000
        : s_q.rd_idx + 10'h001;
    if (!s_q.running)
    begin
      if (!TRIG_MODE || trig_rise)
      begin
        s_d.running = 1'b1;
        s_d.rd_idx = start_idx;
        s_d.acc = '0;
      end
    end
    else if (step)
    begin
      s_d.acc = acc_up;
      s_d.rd_idx = nxt;
      if (TRIG_MODE && nxt == start_idx)
        s_d.running = 1'b0;
    end
    else
      s_d.acc = acc_up;

    case (s_q.state)
      wave_shaper_pkg::ST_IDLE:
        if (s_q.dirty)
        begin
          s_d.dirty = 1'b0;
          s_d.cshape = s_q.shape_seen;
          s_d.cn = n_for(s_q.prm.period);
          s_d.state = wave_shaper_pkg::ST_SETUP;
        end
      wave_shaper_pkg::ST_SETUP:
      begin
        s_d.ci = '0;
        s_d.state = wave_shaper_pkg::ST_POINT;
        case (s_q.cshape)
          wave_shaper_pkg::SHP_SQUARE:
          begin
            s_d.b0 = '0;
            s_d.b1 = '0;
            s_d.b2 = pct_pts(s_q.prm.duty, s_q.cn);
            s_d.b3 = pct_pts(s_q.prm.duty, s_q.cn);
          end
          wave_shaper_pkg::SHP_TRI:
          begin
            s_d.b0 = '0;
            s_d.b1 = s_q.cn >> 1;
            s_d.b2 = s_q.cn >> 1;
            s_d.b3 = s_q.cn;
          end
          wave_shaper_pkg::SHP_RAMP:
          begin
            s_d.b0 = pct_pts(s_q.prm.rdel, s_q.cn);
            s_d.b1 = pct_pts(7'(s_q.prm.rdel + s_q.prm.rris), s_q.cn);
            s_d.b2 = s_d.b1;
            s_d.b3 = pct_pts(7'(s_q.prm.rdel + s_q.prm.rris + s_q.prm.rfal),
                             s_q.cn);
          end
          default:
          begin
            // high portion between rise and fall
            s_d.b0 = pct_pts(s_q.prm.pdel, s_q.cn);
            s_d.b1 = pct_pts(7'(s_q.prm.pdel + s_q.prm.pris), s_q.cn);
            s_d.b2 = pct_pts(7'(s_q.prm.pdel + s_q.prm.pris + s_q.prm.phig),
                             s_q.cn);
            s_d.b3 = pct_pts(7'(s_q.prm.pdel + s_q.prm.pris + s_q.prm.phig
                             + s_q.prm.pfal), s_q.cn);
          end
        endcase
      end
      wave_shaper_pkg::ST_POINT:
        // flat level outside the shape; likewise
        if (s_q.ci < s_q.b0 || s_q.ci >= s_q.b3)
        begin
          val = wave_shaper_pkg::SAMPLE_LOW;
          adv = 1'b1;
        end
        else if (s_q.ci >= s_q.b1 && s_q.ci < s_q.b2)
        begin
          val = wave_shaper_pkg::SAMPLE_MAX;
          adv = 1'b1;
        end
        else
        begin
          s_d.fall = s_q.ci >= s_q.b2;
          div_go = 1'b1;
          div_num = s_d.fall
            ? 22'(s_q.ci - s_q.b2) * 22'(wave_shaper_pkg::SAMPLE_MAX)
            : 22'(s_q.ci - s_q.b0) * 22'(wave_shaper_pkg::SAMPLE_MAX);
          div_den = s_d.fall ? 22'(s_q.b3 - s_q.b2) : 22'(s_q.b1 - s_q.b0);
          s_d.state = wave_shaper_pkg::ST_DIV;
        end
      wave_shaper_pkg::ST_DIV:
        if (div_done)
        begin
          val = s_q.fall ? wave_shaper_pkg::SAMPLE_MAX - div_quo[11:0]
                         : div_quo[11:0];
          adv = 1'b1;
        end
      default: s_d.state = wave_shaper_pkg::ST_IDLE;
    endcase

    if (adv)
    begin
      wr_en = 1'b1;
      wr_addr = s_q.ci;
      wr_data = val;
      s_d.state = wave_shaper_pkg::ST_POINT;
      s_d.ci = s_q.ci + 10'h001;
      if (s_q.ci == s_q.cn - 10'h001)
      begin
        // new table goes live; size becomes cn
        s_d.state = wave_shaper_pkg::ST_IDLE;
        s_d.npts = s_q.cn;
        s_d.shape_act = s_q.cshape;
        s_d.tbl_ok = 1'b1;
        s_d.rd_idx = '0;
        s_d.acc = '0;
        s_d.running = 1'b0;
      end
    end

    // Set wins over the clear taken in idle
    if (ev || SHAPE_SEL != s_q.shape_seen)
      s_d.dirty = 1'b1;
    s_d.busy = s_d.dirty || s_d.state != wave_shaper_pkg::ST_IDLE;
    s_d.dac = s_q.tbl_ok ? scale_out(tbl_rd, s_q.prm.amp, s_q.prm.offs)
                         : wave_shaper_pkg::SAMPLE_MID;
  end

  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
      s_q <= S_RST;
    else
      s_q <= s_d;
  end

  // Table port, no reset: contents gated by tbl_ok
  always_ff @(posedge REF_CLK)
  begin
    if (wr_en)
      table_mem[wr_addr] <= wr_data;
  end

  assign DAC_DATA = s_q.dac;
  assign SAMPLE_VALID = s_q.valid;
  assign TABLE_BUSY = s_q.busy;
  assign PARAM_REJECT = s_q.reject;
  assign TABLE_POINTS = s_q.npts;

  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RST);

  sequence s_settled;
    s_q.state == wave_shaper_pkg::ST_IDLE && !s_q.dirty && s_q.tbl_ok;
  endsequence
  sequence s_amp_wr;
    WR_STB && WR_ID == wave_shaper_pkg::PID_AMP;
  endsequence
  sequence s_offs_wr;
    WR_STB && WR_ID == wave_shaper_pkg::PID_OFFS;
  endsequence

  property p_full_table;
    s_settled ##0 (s_q.prm.period >= 20'd1000) |-> s_q.npts == 10'd1000;
  endproperty
  a_full_table: assert property (p_full_table)
    else $error("table not 1000 points at low rate");

  property p_step;
    (s_q.running && !TRIG_MODE && s_q.npts < 10'd1000 &&
     s_q.state == wave_shaper_pkg::ST_IDLE && s_q.rd_idx < s_q.npts - 10'd1)
    |=> s_q.rd_idx == $past(s_q.rd_idx) + 10'd1;
  endproperty
  a_step: assert property (p_step)
    else $error("point not advanced each clock");

  property p_short_table;
    s_settled ##0 (s_q.prm.period < 20'd1000 && s_q.prm.period >= 20'd10)
    |-> s_q.npts == s_q.prm.period[9:0];
  endproperty
  a_short_table: assert property (p_short_table)
    else $error("point count not shrunk");

  property p_min_pts;
    s_q.npts >= 10'd10;
  endproperty
  a_min_pts: assert property (p_min_pts)
    else $error("fewer than ten points");

  property p_trig_start;
    (TRIG_MODE && !s_q.running && trig_rise &&
     s_q.state == wave_shaper_pkg::ST_IDLE)
    |=> (s_q.rd_idx == $past(start_idx) && s_q.running) ##1 SAMPLE_VALID;
  endproperty
  a_trig_start: assert property (p_trig_start)
    else $error("trigger did not start at phase");

  property p_flat_tail;
    (s_q.state == wave_shaper_pkg::ST_POINT && s_q.ci >= s_q.b3)
    |-> wr_en && wr_data == 12'h000;
  endproperty
  a_flat_tail: assert property (p_flat_tail)
    else $error("tail of period not flat");

  property p_recalc;
    (WR_STB && WR_ID == wave_shaper_pkg::PID_RESTORE) |=> TABLE_BUSY;
  endproperty
  a_recalc: assert property (p_recalc)
    else $error("no recompute after change");

  property p_coherent;
    s_settled ##0 (WR_STB && WR_ID == wave_shaper_pkg::PID_PERIOD &&
    WR_VAL >= 16'd1000 && s_q.prm.period >= 20'd1000 &&
    SHAPE_SEL == s_q.shape_seen) |=> !TABLE_BUSY;
  endproperty
  a_coherent: assert property (p_coherent)
    else $error("low rate change forced recompute");

  property p_amp;
    s_amp_wr |=> s_q.prm.amp == $past(WR_VAL[11:0]);
  endproperty
  a_amp: assert property (p_amp)
    else $error("amplitude not replaced");

  property p_offs;
    s_offs_wr |=> s_q.prm.offs == $past(WR_VAL[11:0]);
  endproperty
  a_offs: assert property (p_offs)
    else $error("offset not replaced");

  property p_restore;
    (WR_STB && WR_ID == wave_shaper_pkg::PID_RESTORE &&
     WR_SHAPE == wave_shaper_pkg::SHP_SQUARE)
    |=> s_q.prm.duty == 7'd50 && s_q.prm.amp == 12'h800;
  endproperty
  a_restore: assert property (p_restore)
    else $error("defaults not restored");

  property p_reject;
    (WR_STB && WR_SHAPE == wave_shaper_pkg::SHP_RAMP &&
     WR_ID == wave_shaper_pkg::PID_DELAY &&
     {1'b0, WR_VAL} + 17'(s_q.prm.rris) + 17'(s_q.prm.rfal) > 17'd100)
    |=> PARAM_REJECT && s_q.prm == $past(s_q.prm);
  endproperty
  a_reject: assert property (p_reject)
    else $error("over-full update accepted");

  property p_high;
    (s_q.state == wave_shaper_pkg::ST_POINT && s_q.ci >= s_q.b1 &&
     s_q.ci < s_q.b2 && s_q.ci >= s_q.b0 && s_q.ci < s_q.b3)
    |-> wr_en && wr_data == 12'hFFF;
  endproperty
  a_high: assert property (p_high)
    else $error("high portion not at full level");

endmodule

// >>> wave_shaper_pkg.sv
/*
  Shared constants and types for the standard waveform shaper: table
  sizes, parameter identifiers, shape codes, factory defaults and the
  recompute state encoding. Assumes a single sample clock domain.
*/
package wave_shaper_pkg;

  // Sample clock
  localparam int CLK_HZ     = 20_000_000;
  localparam int CLK_NS     = 50;

  // Table geometry
  localparam int SAMPLE_W   = 12;
  localparam int IDX_W      = 10;
  localparam int PER_W      = 20;
  localparam int DIV_W      = 22;
  localparam int TBL_PTS    = 1000;
  localparam int MIN_PTS    = 10;
  localparam int PCT_FULL   = 100;
  localparam int DEG_FULL   = 360;

  localparam logic [11:0] SAMPLE_MAX = 12'hFFF;
  localparam logic [11:0] SAMPLE_MID = 12'h800;
  localparam logic [11:0] SAMPLE_LOW = 12'h000;

  // Shape codes
  localparam logic [1:0] SHP_SQUARE = 2'h0;
  localparam logic [1:0] SHP_TRI    = 2'h1;
  localparam logic [1:0] SHP_RAMP   = 2'h2;
  localparam logic [1:0] SHP_PULSE  = 2'h3;

  // Parameter identifiers
  localparam logic [3:0] PID_PERIOD  = 4'h0;
  localparam logic [3:0] PID_AMP     = 4'h1;
  localparam logic [3:0] PID_OFFS    = 4'h2;
  localparam logic [3:0] PID_DUTY    = 4'h3;
  localparam logic [3:0] PID_PHASE   = 4'h4;
  localparam logic [3:0] PID_DELAY   = 4'h5;
  localparam logic [3:0] PID_RISE    = 4'h6;
  localparam logic [3:0] PID_HIGH    = 4'h7;
  localparam logic [3:0] PID_FALL    = 4'h8;
  localparam logic [3:0] PID_RESTORE = 4'h9;

  // Factory defaults
  localparam logic [19:0] DEF_PERIOD = 20'h003E8;
  localparam logic [11:0] DEF_AMP    = 12'h800;
  localparam logic [11:0] DEF_OFFS   = 12'h000;
  localparam logic [6:0]  DEF_DUTY   = 7'h32;
  localparam logic [8:0]  DEF_PHASE  = 9'h000;
  localparam logic [6:0]  DEF_RDEL   = 7'h00;
  localparam logic [6:0]  DEF_RRIS   = 7'h32;
  localparam logic [6:0]  DEF_RFAL   = 7'h32;
  localparam logic [6:0]  DEF_PDEL   = 7'h0A;
  localparam logic [6:0]  DEF_PRIS   = 7'h0A;
  localparam logic [6:0]  DEF_PHIG   = 7'h1E;
  localparam logic [6:0]  DEF_PFAL   = 7'h0A;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_SETUP = 2'b01,
    ST_POINT = 2'b10,
    ST_DIV   = 2'b11
  } rec_state_t;

  typedef struct packed {
    logic [19:0] period;
    logic [11:0] amp;
    logic [11:0] offs;
    logic [6:0]  duty;
    logic [8:0]  phase;
    logic [6:0]  rdel;
    logic [6:0]  rris;
    logic [6:0]  rfal;
    logic [6:0]  pdel;
    logic [6:0]  pris;
    logic [6:0]  phig;
    logic [6:0]  pfal;
  } params_t;

  localparam params_t PRM_DEF = '{DEF_PERIOD, DEF_AMP, DEF_OFFS, DEF_DUTY,
    DEF_PHASE, DEF_RDEL, DEF_RRIS, DEF_RFAL, DEF_PDEL, DEF_PRIS, DEF_PHIG,
    DEF_PFAL};

endpackage

// >>> wave_divider.sv
/*
  Restoring unsigned divider, one quotient bit per clock.
  Assumes den is non-zero and start is a single-cycle pulse while idle.
*/
`timescale 1ns/1ps
module wave_divider #(
  parameter int W = 22
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // Request
  input  wire logic         start,
  input  wire logic [W-1:0] num,
  input  wire logic [W-1:0] den,
  // Answer
  output logic              done,
  output logic [W-1:0]      quo
);

  typedef struct packed {
    logic         busy;
    logic [5:0]   cnt;
    logic [W:0]   rem;
    logic [W-1:0] q;
    logic [W-1:0] d;
    logic         done;
  } div_state_t;

  div_state_t s_q;
  div_state_t s_d;
  logic [W:0] r;

  always_comb
  begin
    s_d = s_q;
    r = '0;
    s_d.done = 1'b0;
    if (start && !s_q.busy)
    begin
      s_d.busy = 1'b1;
      s_d.cnt = 6'(W);
      s_d.rem = '0;
      s_d.q = num;
      s_d.d = den;
    end
    else if (s_q.busy)
    begin
      r = {s_q.rem[W-1:0], s_q.q[W-1]};
      s_d.q = {s_q.q[W-2:0], 1'b0};
      if (r >= {1'b0, s_q.d})
      begin
        r = r - {1'b0, s_q.d};
        s_d.q[0] = 1'b1;
      end
      s_d.rem = r;
      s_d.cnt = s_q.cnt - 6'h01;
      if (s_q.cnt == 6'h01)
      begin
        s_d.busy = 1'b0;
        s_d.done = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign done = s_q.done;
  assign quo = s_q.q;

endmodule

// >>> dac_model.sv
/*
  Converter stand-in: counts samples above mid scale while valid.
  Assumes it shares the shaper's sample clock.
*/
`timescale 1ns/1ps
module dac_model (
  // Clock and control
  input  wire logic        clk,
  input  wire logic        clr,
  // Sample stream
  input  wire logic [11:0] dac_data,
  input  wire logic        sample_valid,
  // Tally
  output int               hi_cnt
);
  always @(posedge clk)
  begin
    if (clr)
      hi_cnt <= 0;
    else if (sample_valid && dac_data > 12'h800)
      hi_cnt <= hi_cnt + 1;
  end
endmodule

// >>> testbench.sv
/*
  Self-checking bench for the waveform shaper.
  Assumes the shaper and converter model share one 20 MHz clock.
*/
`timescale 1ns/1ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin errors++; \
  $display("Error %s exp %0h got %0h", n, e, g); end end
module testbench;
  logic        ref_clk, rst, wr_stb, clr, rj, trig_mode, trig_in;
  logic [1:0]  shape_sel, wr_shape;
  logic [3:0]  wr_id;
  logic [15:0] wr_val;
  logic [11:0] dac_data;
  logic        sample_valid, table_busy, param_reject;
  logic [9:0]  table_points;
  int          errors, checked, cycles, hi_cnt;

  wave_shaper wave_shaper_i (.REF_CLK(ref_clk), .RST(rst),
    .SHAPE_SEL(shape_sel), .TRIG_MODE(trig_mode), .TRIG_IN(trig_in),
    .WR_STB(wr_stb), .WR_SHAPE(wr_shape), .WR_ID(wr_id), .WR_VAL(wr_val),
    .DAC_DATA(dac_data), .SAMPLE_VALID(sample_valid),
    .TABLE_BUSY(table_busy), .PARAM_REJECT(param_reject),
    .TABLE_POINTS(table_points));
  dac_model dac_model_i (.clk(ref_clk), .clr(clr), .dac_data(dac_data),
    .sample_valid(sample_valid), .hi_cnt(hi_cnt));

  initial
  begin
    ref_clk = 0;
    forever #25 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 100000)
    begin
      errors++;
      test_done();
    end
  end

  task test_done;
    $display("errors=%0d checked=%0d", errors, checked);
    if (errors == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // Write one field, expect refusal or not
  task wr(input logic [1:0] s, input logic [3:0] id, input logic [15:0] v,
          input logic rej);
    @(posedge ref_clk);
    #5 wr_stb = 1;
    wr_shape = s;
    wr_id = id;
    wr_val = v;
    @(posedge ref_clk);
    #5 wr_stb = 0;
    rj = param_reject;
    @(posedge ref_clk);
    #5 rj = rj | param_reject;
    `CHK("reject", rej, rj)
  endtask

  task idle;
    int n;
    n = 0;
    while (table_busy !== 1'b0 && n < 40000)
    begin
      @(posedge ref_clk);
      #5 n++;
    end
    `CHK("busy", 1'b0, table_busy)
  endtask

  // Count high samples over a window of n clocks
  task highs(input int n, input int exp);
    @(posedge ref_clk);
    #5 clr = 1;
    @(posedge ref_clk);
    #5 clr = 0;
    repeat (n) @(posedge ref_clk);
    #5 `CHK("highs", exp, hi_cnt)
  endtask

  // One trigger: highs in first three samples, then whole period
  task trig(input int e3, input int e10);
    @(posedge ref_clk);
    #5 `CHK("valid", 1'b0, sample_valid)
    clr = 1;
    trig_in = 1;
    @(posedge ref_clk);
    #5 clr = 0;
    trig_in = 0;
    repeat (6) @(posedge ref_clk);
    #5 `CHK("first", e3, hi_cnt)
    `CHK("valid", 1'b1, sample_valid)
    repeat (10) @(posedge ref_clk);
    #5 `CHK("period", e10, hi_cnt)
    `CHK("valid", 1'b0, sample_valid)
  endtask

  initial
  begin
    rst = 1;
    clr = 0;
    trig_mode = 0;
    trig_in = 0;
    wr_stb = 0;
    shape_sel = wave_shaper_pkg::SHP_SQUARE;
    wr_shape = 0;
    wr_id = 0;
    wr_val = 0;
    repeat (10) @(posedge ref_clk);
    #5 `CHK("points", 10'd1000, table_points)
    `CHK("dac", 12'h800, dac_data)
    rst = 0;
    idle();
    `CHK("points", 10'd1000, table_points)
    highs(1000, 500);
    wr(wave_shaper_pkg::SHP_SQUARE, wave_shaper_pkg::PID_PERIOD, 10, 0);
    idle();
    `CHK("points", 10'd10, table_points)
    highs(100, 50);
    wr(wave_shaper_pkg::SHP_SQUARE, wave_shaper_pkg::PID_DUTY, 30, 0);
    idle();
    highs(100, 30);
    wr(wave_shaper_pkg::SHP_TRI, wave_shaper_pkg::PID_DUTY, 50, 1);
    wr(wave_shaper_pkg::SHP_RAMP, wave_shaper_pkg::PID_RISE, 60, 1);
    wr(wave_shaper_pkg::SHP_PULSE, wave_shaper_pkg::PID_HIGH, 80, 1);
    wr(wave_shaper_pkg::SHP_SQUARE, 4'hA, 0, 1);
    wr(wave_shaper_pkg::SHP_SQUARE, wave_shaper_pkg::PID_PERIOD, 20, 0);
    idle();
    `CHK("points", 10'd20, table_points)
    highs(100, 30);
    wr(wave_shaper_pkg::SHP_RAMP, wave_shaper_pkg::PID_AMP, 0, 0);
    highs(100, 0);
    wr(wave_shaper_pkg::SHP_TRI, wave_shaper_pkg::PID_OFFS, 1, 0);
    highs(100, 100);
    wr(wave_shaper_pkg::SHP_SQUARE, wave_shaper_pkg::PID_RESTORE, 0, 0);
    idle();
    `CHK("points", 10'd1000, table_points)
    highs(1000, 500);
    wr(wave_shaper_pkg::SHP_SQUARE, wave_shaper_pkg::PID_PERIOD, 2000, 0);
    `CHK("busy", 1'b0, table_busy)
    highs(2000, 1000);
    shape_sel = wave_shaper_pkg::SHP_RAMP;
    repeat (2) @(posedge ref_clk);
    #5 `CHK("busy", 1'b1, table_busy)
    idle();
    `CHK("points", 10'd1000, table_points)
    wr(wave_shaper_pkg::SHP_RAMP, wave_shaper_pkg::PID_PERIOD, 5, 0);
    idle();
    `CHK("points", 10'd10, table_points)
    wr(wave_shaper_pkg::SHP_TRI, wave_shaper_pkg::PID_PHASE, 180, 0);
    trig_mode = 1;
    shape_sel = wave_shaper_pkg::SHP_TRI;
    @(posedge ref_clk);
    #5 idle();
    trig(3, 5);
    trig_mode = 0;
    shape_sel = wave_shaper_pkg::SHP_PULSE;
    @(posedge ref_clk);
    #5 idle();
    highs(100, 40);
    test_done();
  end
endmodule
